/* core/dual_port_sram_port_counter_ctrl.sv */
// Port control for one port of a synchronous dual-port memory
// How it works
// - All inputs but output enable and flow/pipe select are clocked; output enable gates drivers directly, flow/pipe select picks the output register directly.
// - Chip select high floats the data outputs after the next edge in flow-through, after the second edge in pipelined.
// - Byte mode takes four beats per word, word mode two.
// - Strobe held low with count enable low loads the external address every edge.
// - Pipelined outputs follow controls sampled in the previous cycle.
// - Counter reset adds no idle cycle; access may share that cycle.
// - Byte mode extends the counter address readout by one cycle.
// - Chip select, read/write and output enable decode deselect, write, read or float.
// - Pipelined chip-select changes take effect one cycle later.
// - Counter reset wins; strobe high, count enable low increments.
// - Strobe and count enable low load the external address.
// - Strobe low, count enable high, read drives the counter on the pins.
// - Strobe and count enable high hold the counter.
// - Counter modes work while deselected.
// - Flow/pipe select low is flow-through, high is pipelined.
// - On the right port, bus match and width select pick 36, 18 or 9 bit width; the left port is fixed at 36.
// - Sub-counter counts up little-endian, down big-endian, in increment only.
`timescale 1ns/1ps
module dual_port_sram_port_counter_ctrl #(
  parameter bit RIGHT_PORT = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Port controls
  input wire logic chip_select_n,
  input wire logic read_write,
  input wire logic output_enable_n,
  input wire logic [3:0] lane_select_n,
  input wire logic [dp_port_pkg::ADDR_W-1:0] ext_addr,
  // Counter controls
  input wire logic address_strobe_n,
  input wire logic count_enable_n,
  input wire logic counter_reset_n,
  // Configuration
  input wire logic flow_pipe_select,
  input wire logic bus_match_select,
  input wire logic width_select,
  input wire logic endian_order_select,
  // Data pins
  input wire logic [dp_port_pkg::DATA_W-1:0] data_in,
  output logic [dp_port_pkg::DATA_W-1:0] data_out,
  output logic [dp_port_pkg::DATA_W-1:0] data_oe,
  // Memory array side
  output logic [dp_port_pkg::ADDR_W-1:0] mem_addr,
  output logic [3:0] mem_lane_we,
  output logic [dp_port_pkg::DATA_W-1:0] mem_wdata,
  input wire logic [dp_port_pkg::DATA_W-1:0] mem_rdata
);
  localparam int LW = dp_port_pkg::LANE_W;
  port_cnt_if cnt_bus ();
  logic [1:0] width_code;
  logic [1:0] width_r;
  logic [3:0] lane_mask;
  logic [1:0] lane_of_beat;
  logic is_write;
  logic is_read;
  logic readout;
  logic readout_ext_r;
  logic [dp_port_pkg::DATA_W-1:0] beat_word;
  logic [dp_port_pkg::DATA_W-1:0] addr_word;
  logic [dp_port_pkg::DATA_W-1:0] out_nxt;
  logic drive_nxt;
  logic [dp_port_pkg::DATA_W-1:0] flow_out_r;
  logic flow_drive_r;
  logic [dp_port_pkg::DATA_W-1:0] pipe_out_r;
  logic pipe_drive_r;

  assign width_code = RIGHT_PORT ? {bus_match_select, width_select} : dp_port_pkg::WIDTH_36;

  // Width settles one cycle after a pin change
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      width_r <= dp_port_pkg::WIDTH_36;
    end else begin
      width_r <= width_code;
    end
  end

  port_addr_counter #(.HAS_SUB(RIGHT_PORT)) u_counter (
    .ref_clk(ref_clk),
    .rst(rst),
    .address_strobe_n(address_strobe_n),
    .count_enable_n(count_enable_n),
    .counter_reset_n(counter_reset_n),
    .output_enable_n(output_enable_n),
    .read_write(read_write),
    .ext_addr(ext_addr),
    .width_code(width_r),
    .endian_order_select(endian_order_select),
    .cnt(cnt_bus.owner)
  );

  assign mem_addr = cnt_bus.addr;

  // Beat picks the active lane group in 18 and 9 bit widths; lane selects pick it in 36
  assign lane_of_beat = cnt_bus.sub;
  always_comb begin
    case (width_r)
      dp_port_pkg::WIDTH_9: lane_mask = 4'h1 << lane_of_beat;
      dp_port_pkg::WIDTH_18: lane_mask = lane_of_beat[0] ? 4'hC : 4'h3;
      default: lane_mask = ~lane_select_n;
    endcase
  end

  assign is_write = !chip_select_n && !read_write;
  assign is_read = !chip_select_n && read_write;
  // Hold plus read shows the counter
  assign readout = cnt_bus.mode == dp_port_pkg::CM_HOLD_READ;

  // Write in same cycle as counter reset
  assign mem_lane_we = is_write ? lane_mask : 4'h0;

  // Narrow bus data steered into its lane group
  always_comb begin
    mem_wdata = data_in;
    case (width_r)
      dp_port_pkg::WIDTH_9: mem_wdata = {4{data_in[LW-1:0]}};
      dp_port_pkg::WIDTH_18: mem_wdata = {2{data_in[2*LW-1:0]}};
      default: mem_wdata = data_in;
    endcase
  end

  // Read beat moved down to the low pins
  always_comb begin
    beat_word = mem_rdata;
    case (width_r)
      dp_port_pkg::WIDTH_9: beat_word = {27'h0, mem_rdata[lane_of_beat*LW +: LW]};
      dp_port_pkg::WIDTH_18: beat_word = {18'h0, mem_rdata[lane_of_beat[0]*2*LW +: 2*LW]};
      default: beat_word = mem_rdata;
    endcase
  end

  // Byte readout: high bits, then low bits
  always_comb begin
    addr_word = '0;
    case (width_r)
      dp_port_pkg::WIDTH_9: begin
        if (!readout_ext_r) begin
          addr_word[dp_port_pkg::RD9_HI_BITS-1:0] = cnt_bus.addr[dp_port_pkg::ADDR_W-1:6];
        end else begin
          addr_word[dp_port_pkg::RD9_LO_LSB +: 8] = {cnt_bus.sub, cnt_bus.addr[5:0]};
        end
      end
      dp_port_pkg::WIDTH_18: addr_word[dp_port_pkg::RD18_LSB +: 16] = {cnt_bus.sub[0], cnt_bus.addr};
      default: addr_word[dp_port_pkg::RD36_LSB +: dp_port_pkg::ADDR_W] = cnt_bus.addr;
    endcase
  end

  // Second readout cycle in byte mode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      readout_ext_r <= 1'b0;
    end else begin
      readout_ext_r <= readout && width_r == dp_port_pkg::WIDTH_9 && !readout_ext_r;
    end
  end

  assign out_nxt = readout ? addr_word : beat_word;
  // Enable left out: it acts on the drivers without the clock
  assign drive_nxt = is_read;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flow_out_r <= '0;
      flow_drive_r <= 1'b0;
    end else begin
      flow_out_r <= out_nxt;
      flow_drive_r <= drive_nxt;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pipe_out_r <= '0;
      pipe_drive_r <= 1'b0;
    end else begin
      pipe_out_r <= flow_out_r;
      pipe_drive_r <= flow_drive_r;
    end
  end

  // Output enable gates drivers without the clock
  assign data_out = flow_pipe_select ? pipe_out_r : flow_out_r;
  assign data_oe = {dp_port_pkg::DATA_W{(flow_pipe_select ? pipe_drive_r : flow_drive_r) && !output_enable_n}};

  // Pin side checks
  a_deselect_float: assert property (@(posedge ref_clk) disable iff (rst)
    chip_select_n && !flow_pipe_select |=> data_oe == '0)
    else $error("outputs driven after deselect");
  a_pipe_lag: assert property (@(posedge ref_clk) disable iff (rst)
    is_read && flow_pipe_select |=> ##1 (output_enable_n || flow_pipe_select == 1'b0 || data_oe[0]))
    else $error("pipelined read did not drive");
  a_flow_drive: assert property (@(posedge ref_clk) disable iff (rst)
    is_read && !flow_pipe_select |=> (flow_pipe_select || data_oe[0] == !output_enable_n))
    else $error("flow-through read did not drive");
  a_oe_async: assert property (@(posedge ref_clk) disable iff (rst)
    output_enable_n |-> data_oe == '0)
    else $error("drivers on with output enable high");
  a_write_lanes: assert property (@(posedge ref_clk) disable iff (rst)
    !is_write |-> mem_lane_we == 4'h0)
    else $error("write strobe without write");
  a_byte_lane: assert property (@(posedge ref_clk) disable iff (rst)
    is_write && width_r == dp_port_pkg::WIDTH_9 |-> $onehot(mem_lane_we))
    else $error("byte write touched more than one lane");

  // Readout checks
  a_readout_pins: assert property (@(posedge ref_clk) disable iff (rst)
    readout && width_r == dp_port_pkg::WIDTH_36
    |=> flow_out_r[dp_port_pkg::RD36_LSB +: dp_port_pkg::ADDR_W] == $past(cnt_bus.addr))
    else $error("counter value missing on the pins");
  a_byte_readout: assert property (@(posedge ref_clk) disable iff (rst)
    readout && width_r == dp_port_pkg::WIDTH_9 && !readout_ext_r |=> readout_ext_r)
    else $error("byte readout not extended");
endmodule : dual_port_sram_port_counter_ctrl

/* core/dp_port_pkg.sv */
// Constants and types shared by the port control block
package dp_port_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int SUB_W = 2;
  // Counter readout field positions on the data pins
  localparam int RD36_LSB = 3;
  localparam int RD18_LSB = 2;
  localparam int RD9_HI_BITS = 9;
  localparam int RD9_LO_LSB = 1;
  localparam logic [SUB_W-1:0] SUB_RESET = 2'h0;
  localparam logic [ADDR_W-1:0] CNT_RESET = 15'h0000;
  // Width codes {bus_match_select, width_select}
  localparam logic [1:0] WIDTH_36 = 2'h0;
  localparam logic [1:0] WIDTH_18 = 2'h2;
  localparam logic [1:0] WIDTH_9 = 2'h3;
  localparam int BEATS_9 = 4;
  localparam int BEATS_18 = 2;
  typedef enum logic [2:0] {
    CM_RESET = 3'h0,
    CM_LOAD = 3'h1,
    CM_HOLD_READ = 3'h2,
    CM_HOLD = 3'h3,
    CM_INCR = 3'h4
  } cnt_mode_t;
endpackage : dp_port_pkg

/* core/port_cnt_if.sv */
// Counter state passed from the counter to the port logic
`timescale 1ns/1ps
interface port_cnt_if;
  logic [dp_port_pkg::ADDR_W-1:0] addr;
  logic [dp_port_pkg::SUB_W-1:0] sub;
  dp_port_pkg::cnt_mode_t mode;
  modport owner (output addr, output sub, output mode);
  modport user (input addr, input sub, input mode);
endinterface : port_cnt_if

/* core/port_addr_counter.sv */
// Burst address counter with bus-match sub-counter
`timescale 1ns/1ps
module port_addr_counter #(
  parameter bit HAS_SUB = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Counter controls
  input wire logic address_strobe_n,
  input wire logic count_enable_n,
  input wire logic counter_reset_n,
  input wire logic output_enable_n,
  input wire logic read_write,
  input wire logic [dp_port_pkg::ADDR_W-1:0] ext_addr,
  input wire logic [1:0] width_code,
  input wire logic endian_order_select,
  // To port logic
  port_cnt_if.owner cnt
);
  dp_port_pkg::cnt_mode_t mode;
  logic [dp_port_pkg::ADDR_W-1:0] addr_r;
  logic [dp_port_pkg::SUB_W-1:0] sub_r;
  logic [dp_port_pkg::SUB_W-1:0] sub_last;
  logic sub_wrap;

  always_comb begin
    if (!counter_reset_n) begin
      mode = dp_port_pkg::CM_RESET;
    end else if (!address_strobe_n && !count_enable_n) begin
      mode = dp_port_pkg::CM_LOAD;
    end else if (!address_strobe_n && !output_enable_n && read_write) begin
      mode = dp_port_pkg::CM_HOLD_READ;
    end else if (!count_enable_n) begin
      mode = dp_port_pkg::CM_INCR;
    end else begin
      mode = dp_port_pkg::CM_HOLD;
    end
  end

  // Last beat index of a word for the current width and order
  always_comb begin
    case (width_code)
      dp_port_pkg::WIDTH_9: sub_last = endian_order_select ? 2'h0 : 2'h3;
      dp_port_pkg::WIDTH_18: sub_last = endian_order_select ? 2'h0 : 2'h1;
      default: sub_last = 2'h0;
    endcase
  end
  assign sub_wrap = !HAS_SUB || width_code == dp_port_pkg::WIDTH_36 || sub_r == sub_last;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_r <= dp_port_pkg::CNT_RESET;
      sub_r <= dp_port_pkg::SUB_RESET;
    end else begin
      case (mode)
        dp_port_pkg::CM_RESET: begin
          addr_r <= dp_port_pkg::CNT_RESET;
          sub_r <= dp_port_pkg::SUB_RESET;
        end
        dp_port_pkg::CM_LOAD: begin
          addr_r <= ext_addr;
          sub_r <= (endian_order_select && width_code == dp_port_pkg::WIDTH_9) ? 2'h3 :
                   (endian_order_select && width_code == dp_port_pkg::WIDTH_18) ? 2'h1 : 2'h0;
        end
        dp_port_pkg::CM_INCR: begin
          if (sub_wrap) begin
            addr_r <= addr_r + 1'b1;
            sub_r <= (endian_order_select && width_code == dp_port_pkg::WIDTH_9) ? 2'h3 :
                     (endian_order_select && width_code == dp_port_pkg::WIDTH_18) ? 2'h1 : 2'h0;
          end else begin
            sub_r <= endian_order_select ? sub_r - 1'b1 : sub_r + 1'b1;
          end
        end
        default: begin
          addr_r <= addr_r;
          sub_r <= sub_r;
        end
      endcase
    end
  end

  assign cnt.addr = addr_r;
  assign cnt.sub = sub_r;
  assign cnt.mode = mode;

  // a_reset_clears: reset mode zeroes counter
  a_reset_clears: assert property (@(posedge ref_clk) disable iff (rst)
    !counter_reset_n |=> addr_r == dp_port_pkg::CNT_RESET && sub_r == dp_port_pkg::SUB_RESET)
    else $error("counter not cleared by reset");
  a_load_addr: assert property (@(posedge ref_clk) disable iff (rst)
    counter_reset_n && !address_strobe_n && !count_enable_n |=> addr_r == $past(ext_addr))
    else $error("address not loaded");
  a_hold_stable: assert property (@(posedge ref_clk) disable iff (rst)
    counter_reset_n && address_strobe_n && count_enable_n |=> $stable(addr_r) && $stable(sub_r))
    else $error("counter moved in hold");
  a_readout_hold: assert property (@(posedge ref_clk) disable iff (rst)
    counter_reset_n && !address_strobe_n && count_enable_n |=> $stable(addr_r) && $stable(sub_r))
    else $error("counter moved in hold with readout");
  a_incr_36: assert property (@(posedge ref_clk) disable iff (rst)
    counter_reset_n && address_strobe_n && !count_enable_n && width_code == dp_port_pkg::WIDTH_36
    |=> addr_r == $past(addr_r) + 1'b1)
    else $error("counter did not increment");
endmodule : port_addr_counter

/* tb/mem_array_model.sv */
// Memory array model behind the port, written lane by lane
`timescale 1ns/1ps
module mem_array_model (
  // Clock
  input wire logic ref_clk,
  // Array access
  input wire logic [dp_port_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [3:0] mem_lane_we,
  input wire logic [dp_port_pkg::DATA_W-1:0] mem_wdata,
  output logic [dp_port_pkg::DATA_W-1:0] mem_rdata
);
  logic [dp_port_pkg::DATA_W-1:0] mem_r [0:255];
  // Unwritten words hold a pattern, so a missed write never reads back right
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem_r[i] = {4{9'h0A5}} ^ 36'(i);
    end
  end
  always @(posedge ref_clk) begin
    for (int l = 0; l < 4; l++) begin
      if (mem_lane_we[l]) begin
        mem_r[mem_addr[7:0]][l*9 +: 9] <= mem_wdata[l*9 +: 9];
      end
    end
  end
  assign mem_rdata = mem_r[mem_addr[7:0]];
endmodule : mem_array_model

/* tb/tb.sv */
// Self-checking bench for the port control block
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic chip_select_n, read_write, output_enable_n;
  logic [3:0] lane_select_n, mem_lane_we;
  logic [dp_port_pkg::ADDR_W-1:0] ext_addr, mem_addr;
  logic address_strobe_n, count_enable_n, counter_reset_n;
  logic flow_pipe_select, bus_match_select, width_select, endian_order_select;
  logic [dp_port_pkg::DATA_W-1:0] data_in, data_out, data_oe, mem_wdata, mem_rdata;
  int n_fail = 0;
  int checks_done = 0;
  always #12.5 ref_clk = ~ref_clk;
  dual_port_sram_port_counter_ctrl #(.RIGHT_PORT(1'b1)) u_dut (
    .ref_clk, .rst, .chip_select_n, .read_write, .output_enable_n, .lane_select_n,
    .ext_addr, .address_strobe_n, .count_enable_n, .counter_reset_n, .flow_pipe_select,
    .bus_match_select, .width_select, .endian_order_select, .data_in, .data_out,
    .data_oe, .mem_addr, .mem_lane_we, .mem_wdata, .mem_rdata
  );
  mem_array_model u_mem (.ref_clk, .mem_addr, .mem_lane_we, .mem_wdata, .mem_rdata);
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : tick
  task automatic idle();
    chip_select_n = 1'b1;
    read_write = 1'b1;
    output_enable_n = 1'b1;
    address_strobe_n = 1'b1;
    count_enable_n = 1'b1;
    counter_reset_n = 1'b1;
  endtask : idle
  task automatic load(input logic [14:0] a);
    address_strobe_n = 1'b0;
    count_enable_n = 1'b0;
    ext_addr = a;
    tick();
    address_strobe_n = 1'b1;
    count_enable_n = 1'b1;
  endtask : load
  // Counter modes, all while deselected
  task automatic t_counter();
    load(15'h0100);
    chk(36'(mem_addr), 36'h000000100);
    tick(2);
    chk(36'(mem_addr), 36'h000000100);
    count_enable_n = 1'b0;
    tick(3);
    chk(36'(mem_addr), 36'h000000103);
    // Load and reset requested together: reset must win
    counter_reset_n = 1'b0;
    address_strobe_n = 1'b0;
    tick();
    chk(36'(mem_addr), 36'h000000000);
    idle();
  endtask : t_counter
  task automatic t_wr_rd(input logic pipe);
    flow_pipe_select = pipe;
    load(15'h0020);
    // Location written in the cycle right after the load
    chip_select_n = 1'b0;
    read_write = 1'b0;
    data_in = 36'h987654321 ^ {36{pipe}};
    tick();
    read_write = 1'b1;
    output_enable_n = 1'b0;
    tick(1 + pipe);
    chk(data_oe, {36{1'b1}});
    chk(data_out, 36'h987654321 ^ {36{pipe}});
    output_enable_n = 1'b1;
    #1 chk(data_oe, 36'h000000000);
    // Enable restored on the next falling edge
    tick();
    output_enable_n = 1'b0;
    chip_select_n = 1'b1;
    tick();
    chk(data_oe, {36{pipe}});
    if (pipe) begin
      tick();
    end
    chk(data_oe, 36'h000000000);
    idle();
  endtask : t_wr_rd
  task automatic t_readout();
    flow_pipe_select = 1'b0;
    load(15'h1234);
    chip_select_n = 1'b0;
    output_enable_n = 1'b0;
    address_strobe_n = 1'b0;
    ext_addr = 15'h0777;
    tick(2);
    chk(36'(data_out[17:3]), 36'h000001234);
    chk(36'(mem_addr), 36'h000001234);
    idle();
  endtask : t_readout
  // 18 and 9 bit widths in both orders: word address moves only after the last beat
  task automatic t_bus_match();
    for (int i = 0; i < 4; i++) begin
      bus_match_select = 1'b1;
      width_select = i[0];
      endian_order_select = i[1];
      tick();
      load(15'h0040);
      count_enable_n = 1'b0;
      tick(i[0] ? 3 : 1);
      chk(36'(mem_addr), 36'h000000040);
      tick();
      chk(36'(mem_addr), 36'h000000041);
      count_enable_n = 1'b1;
    end
    bus_match_select = 1'b0;
    width_select = 1'b0;
    tick();
  endtask : t_bus_match
  // Byte bus: big-endian burst write, long-word read back, counter readout
  task automatic t_byte_mode();
    flow_pipe_select = 1'b0;
    bus_match_select = 1'b1;
    width_select = 1'b1;
    endian_order_select = 1'b1;
    tick();
    load(15'h0050);
    chip_select_n = 1'b0;
    read_write = 1'b0;
    count_enable_n = 1'b0;
    for (int b = 0; b < 4; b++) begin
      data_in = {27'h7FFFFFF, 9'h1A0 + 9'(b)};
      tick();
    end
    chk(36'(mem_addr), 36'h000000051);
    idle();
    bus_match_select = 1'b0;
    width_select = 1'b0;
    tick();
    load(15'h0050);
    chip_select_n = 1'b0;
    output_enable_n = 1'b0;
    tick();
    chk(data_out, {9'h1A0, 9'h1A1, 9'h1A2, 9'h1A3});
    idle();
    bus_match_select = 1'b1;
    width_select = 1'b1;
    endian_order_select = 1'b0;
    tick();
    load(15'h1234);
    chip_select_n = 1'b0;
    output_enable_n = 1'b0;
    address_strobe_n = 1'b0;
    tick();
    chk(data_out, 36'h000000048);
    tick();
    chk(data_out, 36'h000000068);
    tick();
    idle();
    bus_match_select = 1'b0;
    width_select = 1'b0;
    tick();
  endtask : t_byte_mode
  task automatic final_report();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  // Hang guard, far beyond the longest sequence
  initial begin
    #1000000;
    n_fail++;
    final_report();
  end
  initial begin
    idle();
    lane_select_n = 4'h0;
    ext_addr = 15'h0000;
    data_in = 36'h000000000;
    flow_pipe_select = 1'b0;
    bus_match_select = 1'b0;
    width_select = 1'b0;
    endian_order_select = 1'b0;
    tick(2);
    chk(data_oe, 36'h000000000);
    chk(36'(mem_addr), 36'h000000000);
    rst = 1'b0;
    tick();
    t_counter();
    t_wr_rd(1'b0);
    t_wr_rd(1'b1);
    t_readout();
    t_bus_match();
    t_byte_mode();
    final_report();
  end
endmodule : tb
